/* File: pbv_channel.v */
// Push-button brightness value transmitter with per-function disable logic
// Contract
// - Rising-edge value 0..1500 lux in 50 lux steps, default 200.
// - Falling-edge value 0..1500 lux in 50 lux steps.
// - Long press steps value cyclically and sends each; last value kept.
// - Adjustment selectable, default off, single-edge modes only.
// - Adjust interval is base times factor; base 130/260/520/1000 ms, default 520.
// - Interval factor 3..127, default 3.
// - Each adjustment step is a fixed 50 lux.
// - After bus return, wait configured delay, then perform configured reaction.
// - Rising/falling reaction sends that edge value, only if mode includes it.
// - Current-input reaction sends value for present level; both-edges mode only.
// - Disable enableable per function; switching uses its own disable object.
// - Disable polarity selectable, default one disables.
// - Two switching objects each have own start action: none/On/Off/Toggle.
// - At disable start, send configured command on each switching object.
// - At switching disable end, send none/On/Off/current input per object.
// - Dimming sends none/On/Off/Toggle on switching object at start and end.
// - Blind sends none/Down/Up/Toggle on long-time object at start and end.
// - Blind toggle reverses stored last direction and sends it.
// - Value transmitter disable start/end: none/rise/fall/current input value.
// - With disable feature off, disable object has no effect.
//
// The register offsets and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pbv_consts.vh"

module pbv_channel #(
	parameter [17:0] CYC_PER_MS = `PBV_CYC_PER_MS
) (
	input  wire        sys_clk,          // System clock
	input  wire        rst,              // Synchronous reset
	input  wire [5:0]  avs_address,      // Byte address
	input  wire        avs_read,         // Read request
	input  wire        avs_write,        // Write request
	input  wire [31:0] avs_writedata,    // Write data
	input  wire [3:0]  avs_byteenable,   // Byte lanes
	output reg  [31:0] avs_readdata,     // Read data
	output reg         avs_waitrequest,  // Stall
	input  wire        contactIn,        // Contact level
	input  wire        busVoltOk,        // Bus voltage present
	output reg         tgValid,          // Telegram strobe
	output reg  [2:0]  tgObject,         // Telegram object
	output reg  [15:0] tgData            // Telegram payload
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	reg  [8:0]  modeReg;
	reg  [4:0]  riseIdx;
	reg  [4:0]  fallIdx;
	reg  [6:0]  factor;
	reg         disEn;
	reg         disPol;
	reg  [7:0]  disAct;
	reg         disObj;
	reg  [15:0] pwrDelayMs;

	wire [1:0]  edgeMode = modeReg[1:0];
	wire        adjEn    = modeReg[2] & (edgeMode != `PBV_EDGE_BOTH);
	wire [1:0]  baseSel  = modeReg[4:3];
	wire [1:0]  pwrReact = modeReg[6:5];
	wire [1:0]  func     = modeReg[8:7];

	wire        busAck   = (avs_read | avs_write) & ~avs_waitrequest;
	wire        wrAck    = busAck & avs_write;

	function [15:0] merge16;
		input [15:0] old;
		input [31:0] wd;
		input [3:0]  be;
		begin
			merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
		end
	endfunction

	wire [15:0] wrMode   = merge16({7'h00, modeReg}, avs_writedata, avs_byteenable);
	wire [15:0] wrRise   = merge16({11'h000, riseIdx}, avs_writedata, avs_byteenable);
	wire [15:0] wrFall   = merge16({11'h000, fallIdx}, avs_writedata, avs_byteenable);
	wire [15:0] wrFactor = merge16({9'h000, factor}, avs_writedata, avs_byteenable);

	// ----------------------------------------------------------------
	// Millisecond tick and interval
	// ----------------------------------------------------------------
	reg  [17:0] preCnt;
	reg         msTick;
	reg  [9:0]  baseMs;

	always @*
	begin
		case (baseSel)
			2'h0:    baseMs = `PBV_BASE0_MS;
			2'h1:    baseMs = `PBV_BASE1_MS;
			2'h2:    baseMs = `PBV_BASE2_MS;
			default: baseMs = `PBV_BASE3_MS;
		endcase
	end

	wire [16:0] intervalMs = {7'h00, baseMs} * {10'h000, factor};

	// ----------------------------------------------------------------
	// Input edges, disable state, reactions
	// ----------------------------------------------------------------
	reg         contactPrev;
	reg         rawDisPrev;
	reg         disEnPrev;
	reg         bvPrev;
	reg         pwrWait;
	reg  [15:0] pwrMs;
	reg  [4:0]  curIdx;
	reg         cfgReload;
	reg         held;
	reg         adjusting;
	reg         adjUp;
	reg  [16:0] holdMs;
	reg  [16:0] adjMs;
	reg  [1:0]  swVal;
	reg         dimSw;
	reg         blindDown;
	reg         pendVal;
	reg  [4:0]  pendIdx;
	reg         pendSw1;
	reg         pendSw2;
	reg         pendDim;
	reg         pendBlind;

	wire rise      = contactIn & ~contactPrev;
	wire fall      = ~contactIn & contactPrev;
	wire rawDis    = disObj ^ disPol;
	wire disNow    = disEn & rawDis;
	// Switching the feature on, alone or together with its polarity, must not fire an action
	wire disChange = disEn & disEnPrev & (rawDis != rawDisPrev);
	wire disStart  = disChange & rawDis;
	wire disEnd    = disChange & ~rawDis;
	wire isValue   = func == `PBV_FUNC_VALUE;
	wire pressEdge = (edgeMode == `PBV_EDGE_RISE) ? rise :
	                 (edgeMode == `PBV_EDGE_FALL) ? fall : 1'b0;
	wire relEdge   = (edgeMode == `PBV_EDGE_RISE) ? fall :
	                 (edgeMode == `PBV_EDGE_FALL) ? rise : 1'b0;
	wire pwrFire   = pwrWait & (pwrMs >= pwrDelayMs);

	// Value reaction: {valid, index}
	function [5:0] valPick;
		input [1:0] code;
		begin
			case (code)
				`PBV_ACT_A: valPick = (edgeMode != `PBV_EDGE_FALL) ?
					{1'b1, riseIdx} : 6'h00;
				`PBV_ACT_B: valPick = (edgeMode != `PBV_EDGE_RISE) ?
					{1'b1, fallIdx} : 6'h00;
				`PBV_ACT_C: valPick = (edgeMode == `PBV_EDGE_BOTH) ?
					{1'b1, contactIn ? riseIdx : fallIdx} : 6'h00;
				default:    valPick = 6'h00;
			endcase
		end
	endfunction

	// Switching object action; end uses current input instead of toggle
	function [1:0] swPick;
		input [1:0] code;
		input       old;
		input       isEnd;
		begin
			case (code)
				`PBV_ACT_A: swPick = 2'h3;
				`PBV_ACT_B: swPick = 2'h2;
				`PBV_ACT_C: swPick = {1'b1, isEnd ? contactIn : ~old};
				default:    swPick = {1'b0, old};
			endcase
		end
	endfunction

	wire [1:0] disCode  = disStart ? disAct[1:0] : disAct[3:2];
	wire [1:0] disCode2 = disStart ? disAct[5:4] : disAct[7:6];
	wire [5:0] disValue = valPick(disCode);
	wire [5:0] pwrValue = valPick(pwrReact);
	wire [1:0] sw1New   = swPick(disCode, swVal[0], disEnd);
	wire [1:0] sw2New   = swPick(disCode2, swVal[1], disEnd);
	wire [1:0] dimNew   = swPick(disCode, dimSw, 1'b0);
	wire       stepTime = adjusting & msTick & (adjMs + 17'h00001 >= intervalMs);
	// Taken on a tick so that the first step interval is a whole base times factor
	wire       longHit  = held & adjEn & ~adjusting & msTick &
	                      (holdMs + 17'h00001 >= `PBV_LONG_MS);
	wire       stepUp   = longHit ? ~adjUp : adjUp;
	wire [4:0] stepIdx  = stepUp ? ((curIdx == `PBV_IDX_MAX) ? curIdx : curIdx + 5'h01) :
	                               ((curIdx == 5'h00) ? curIdx : curIdx - 5'h01);

	// ----------------------------------------------------------------
	// Main sequential logic
	// ----------------------------------------------------------------
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			modeReg <= `PBV_MODE_RST;
			riseIdx <= `PBV_RISE_RST;
			fallIdx <= `PBV_FALL_RST;
			factor <= `PBV_FACTOR_RST;
			disEn <= 1'b0;
			disPol <= 1'b0;
			disAct <= 8'h00;
			disObj <= 1'b0;
			pwrDelayMs <= 16'h0000;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
			preCnt <= 18'h00000;
			msTick <= 1'b0;
			contactPrev <= 1'b0;
			rawDisPrev <= 1'b0;
			disEnPrev <= 1'b0;
			bvPrev <= 1'b0;
			pwrWait <= 1'b0;
			pwrMs <= 16'h0000;
			curIdx <= `PBV_RISE_RST;
			cfgReload <= 1'b0;
			held <= 1'b0;
			adjusting <= 1'b0;
			adjUp <= 1'b1;
			holdMs <= 17'h00000;
			adjMs <= 17'h00000;
			swVal <= 2'h0;
			dimSw <= 1'b0;
			blindDown <= 1'b0;
			pendVal <= 1'b0;
			pendIdx <= 5'h00;
			pendSw1 <= 1'b0;
			pendSw2 <= 1'b0;
			pendDim <= 1'b0;
			pendBlind <= 1'b0;
			tgValid <= 1'b0;
			tgObject <= `PBV_OBJ_VALUE;
			tgData <= 16'h0000;
		end
		else
		begin
			// One-cycle answer to each held request
			avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
			if ((avs_read | avs_write) & avs_waitrequest)
			begin
				case (avs_address)
					`PBV_OFS_MODE:   avs_readdata <= {23'h000000, modeReg};
					`PBV_OFS_RISE:   avs_readdata <= {27'h0000000, riseIdx};
					`PBV_OFS_FALL:   avs_readdata <= {27'h0000000, fallIdx};
					`PBV_OFS_FACTOR: avs_readdata <= {25'h0000000, factor};
					`PBV_OFS_DISCFG: avs_readdata <= {30'h00000000, disPol, disEn};
					`PBV_OFS_DISACT: avs_readdata <= {24'h000000, disAct};
					`PBV_OFS_DISOBJ: avs_readdata <= {31'h00000000, disObj};
					`PBV_OFS_PWRDLY: avs_readdata <= {16'h0000, pwrDelayMs};
					`PBV_OFS_STATUS: avs_readdata <= {20'h00000, curIdx, blindDown,
						dimSw, swVal, adjusting, contactIn, disNow};
					default:         avs_readdata <= 32'h00000000;
				endcase
			end
			cfgReload <= 1'b0;
			if (wrAck)
			begin
				case (avs_address)
					`PBV_OFS_MODE:
					begin
						modeReg <= wrMode[8:0];
						cfgReload <= 1'b1;
					end
					`PBV_OFS_RISE:
					begin
						riseIdx <= (wrRise[4:0] > `PBV_IDX_MAX) ? `PBV_IDX_MAX : wrRise[4:0];
						cfgReload <= 1'b1;
					end
					`PBV_OFS_FALL:
					begin
						fallIdx <= (wrFall[4:0] > `PBV_IDX_MAX) ? `PBV_IDX_MAX : wrFall[4:0];
						cfgReload <= 1'b1;
					end
					`PBV_OFS_FACTOR:
						factor <= (wrFactor[6:0] < `PBV_FACTOR_MIN) ? `PBV_FACTOR_MIN :
							wrFactor[6:0];
					`PBV_OFS_DISCFG:
					begin
						if (avs_byteenable[0])
						begin
							disEn <= avs_writedata[0];
							disPol <= avs_writedata[1];
						end
					end
					`PBV_OFS_DISACT:
						if (avs_byteenable[0])
							disAct <= avs_writedata[7:0];
					`PBV_OFS_DISOBJ:
						if (avs_byteenable[0])
							disObj <= avs_writedata[0];
					`PBV_OFS_PWRDLY:
						pwrDelayMs <= merge16(pwrDelayMs, avs_writedata, avs_byteenable);
					default:
						pwrDelayMs <= pwrDelayMs;
				endcase
			end

			// Millisecond prescaler
			msTick <= 1'b0;
			if (preCnt == CYC_PER_MS - 18'h00001)
			begin
				preCnt <= 18'h00000;
				msTick <= 1'b1;
			end
			else
				preCnt <= preCnt + 18'h00001;

			contactPrev <= contactIn;
			rawDisPrev <= rawDis;
			disEnPrev <= disEn;
			bvPrev <= busVoltOk;

			if (cfgReload)
				curIdx <= (edgeMode == `PBV_EDGE_FALL) ? fallIdx : riseIdx;

			// Bus voltage return, delayed reaction
			if (busVoltOk & ~bvPrev)
			begin
				pwrWait <= 1'b1;
				pwrMs <= 16'h0000;
			end
			else if (~busVoltOk)
				pwrWait <= 1'b0;
			else if (pwrFire)
				pwrWait <= 1'b0;
			else if (pwrWait & msTick)
				pwrMs <= pwrMs + 16'h0001;

			// Press tracking and cyclic adjustment
			if (~isValue | disNow | relEdge)
			begin
				held <= 1'b0;
				adjusting <= 1'b0;
			end
			else if (pressEdge)
			begin
				held <= 1'b1;
				holdMs <= 17'h00000;
			end
			else if (longHit)
			begin
				adjusting <= 1'b1;
				adjUp <= ~adjUp;
				adjMs <= 17'h00000;
			end
			else if (held & msTick)
			begin
				holdMs <= holdMs + 17'h00001;
				adjMs <= stepTime ? 17'h00000 : adjMs + 17'h00001;
			end

			// Telegram output, one per cycle
			tgValid <= 1'b0;
			if (pendSw1)
			begin
				pendSw1 <= 1'b0;
				tgValid <= 1'b1;
				tgObject <= `PBV_OBJ_SW1;
				tgData <= {15'h0000, swVal[0]};
			end
			else if (pendSw2)
			begin
				pendSw2 <= 1'b0;
				tgValid <= 1'b1;
				tgObject <= `PBV_OBJ_SW2;
				tgData <= {15'h0000, swVal[1]};
			end
			else if (pendDim)
			begin
				pendDim <= 1'b0;
				tgValid <= 1'b1;
				tgObject <= `PBV_OBJ_DIMSW;
				tgData <= {15'h0000, dimSw};
			end
			else if (pendBlind)
			begin
				pendBlind <= 1'b0;
				tgValid <= 1'b1;
				tgObject <= `PBV_OBJ_BLIND;
				tgData <= {15'h0000, blindDown};
			end
			else if (pendVal)
			begin
				pendVal <= 1'b0;
				tgValid <= 1'b1;
				tgObject <= `PBV_OBJ_VALUE;
				tgData <= {6'h00, pendIdx, 5'h00} + {7'h00, pendIdx, 4'h0} +
					{10'h000, pendIdx, 1'b0};
			end

			// Disable start and end actions; set wins over the pop above
			if (disChange)
			begin
				case (func)
					`PBV_FUNC_SWITCH:
					begin
						swVal <= {sw2New[0], sw1New[0]};
						pendSw1 <= sw1New[1];
						pendSw2 <= sw2New[1];
					end
					`PBV_FUNC_DIM:
					begin
						dimSw <= dimNew[0];
						pendDim <= dimNew[1];
					end
					`PBV_FUNC_BLIND:
					begin
						if (disCode != `PBV_ACT_NONE)
						begin
							pendBlind <= 1'b1;
							blindDown <= (disCode == `PBV_ACT_C) ? ~blindDown :
								(disCode == `PBV_ACT_A);
						end
					end
					default:
					begin
						if (disValue[5])
						begin
							pendVal <= 1'b1;
							pendIdx <= disValue[4:0];
							curIdx <= disValue[4:0];
						end
					end
				endcase
			end
			else if (pwrFire & isValue & pwrValue[5])
			begin
				pendVal <= 1'b1;
				pendIdx <= pwrValue[4:0];
				curIdx <= pwrValue[4:0];
			end
			else if (isValue & ~disNow)
			begin
				if (edgeMode == `PBV_EDGE_BOTH & (rise | fall))
				begin
					pendVal <= 1'b1;
					pendIdx <= rise ? riseIdx : fallIdx;
					curIdx <= rise ? riseIdx : fallIdx;
				end
				else if (pressEdge)
				begin
					pendVal <= 1'b1;
					pendIdx <= curIdx;
				end
				else if (longHit | stepTime)
				begin
					pendVal <= 1'b1;
					pendIdx <= stepIdx;
					curIdx <= stepIdx;
				end
			end
		end
	end

endmodule

`default_nettype wire

/* File: pbv_channel_checker.sv */
// Concurrent checks on the channel's register bus and telegram ports
`timescale 1ns/1ps
`default_nettype none
`include "pbv_consts.vh"

module pbv_channel_checker #(
	parameter [17:0] CYC_PER_MS = 18'd4
) (
	input wire logic        sys_clk,         // clock
	input wire logic        rst,             // reset
	input wire logic [5:0]  avs_address,     // address
	input wire logic        avs_read,        // read
	input wire logic        avs_write,       // write
	input wire logic [31:0] avs_writedata,   // write data
	input wire logic [3:0]  avs_byteenable,  // lanes
	input wire logic [31:0] avs_readdata,    // read data
	input wire logic        avs_waitrequest, // stall
	input wire logic        contactIn,       // contact
	input wire logic        busVoltOk,       // bus power
	input wire logic        tgValid,         // strobe
	input wire logic [2:0]  tgObject,        // object
	input wire logic [15:0] tgData           // payload
);
	// ------------------------------------------------
	// Bus and telegram properties
	// ------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire rdAck;
	wire valTg;
	assign rdAck = avs_read && !avs_waitrequest;
	assign valTg = tgValid && tgObject == `PBV_OBJ_VALUE;

	AST_WAIT_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered after one wait cycle");
	AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	AST_RISE_RANGE: assert property (rdAck && avs_address == `PBV_OFS_RISE |-> avs_readdata[4:0] <= 5'h1e)
		else $error("rising value index above limit");
	AST_FALL_RANGE: assert property (rdAck && avs_address == `PBV_OFS_FALL |-> avs_readdata[4:0] <= 5'h1e)
		else $error("falling value index above limit");
	AST_FACTOR_MIN: assert property (rdAck && avs_address == `PBV_OFS_FACTOR |-> avs_readdata[6:0] >= 7'h03)
		else $error("interval factor below three");
	AST_LUX_STEP: assert property (valTg |-> tgData <= 16'h05dc && tgData % 16'h0032 == 16'h0000)
		else $error("brightness not a 50 lux step in range");
	AST_VALUE_ALONE: assert property (valTg |=> !tgValid)
		else $error("value telegram not a single pulse");
	AST_CMD_BIT: assert property (tgValid && !valTg |-> tgObject <= 3'h4 && tgData[15:1] == 15'h0000)
		else $error("command telegram malformed");
	AST_RST_QUIET: assert property (disable iff (1'b0) rst |=> !tgValid && avs_waitrequest)
		else $error("activity during reset");
endmodule
`default_nettype wire

/* File: pbv_channel_tb.sv */
// Self-checking bench for the push-button value and disable channel
`timescale 1ns/1ps
`default_nettype none
`include "pbv_consts.vh"

module pbv_channel_tb;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [5:0]  avs_address = 6'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hf;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest;
	wire         contactIn;
	wire         busVoltOk;
	wire         tgValid;
	wire  [2:0]  tgObject;
	wire  [15:0] tgData;
	logic [31:0] rdData;
	logic [50:0] tq[$];
	logic [50:0] ent;
	int          errors = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          stamp;
	int          t0;
	logic [8:0]  dm[3] = '{9'h080, 9'h100, 9'h192};
	logic [7:0]  da[3] = '{8'h07, 8'h0d, 8'h09};
	logic [2:0]  dob[3] = '{3'h3, 3'h4, 3'h0};
	logic [15:0] ds[3] = '{16'h1, 16'h1, 16'h00fa};
	logic [15:0] de[3] = '{16'h1, 16'h0, 16'h0064};

	always #2 sys_clk = ~sys_clk;

	pbv_channel #(.CYC_PER_MS(18'd4)) i_pbv_channel (
		.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .contactIn(contactIn),
		.busVoltOk(busVoltOk), .tgValid(tgValid), .tgObject(tgObject), .tgData(tgData));

	pbv_contact_model i_pbv_contact_model (
		.sys_clk(sys_clk), .contactIn(contactIn), .busVoltOk(busVoltOk));

	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (tgValid === 1'b1)
			tq.push_back({cyc, tgObject, tgData});
	end

	task test_done;
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task timeout;
		errors++;
		$display("mismatch at %0t: wait limit reached", $time);
		test_done;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// Holds the request until the edge that samples waitrequest low
	task xfer(input logic [5:0] a, input logic wr, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 40);
		rdData = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 40)
			timeout;
	endtask

	task rdCheck(input logic [5:0] a, input logic [31:0] exp);
		xfer(a, 1'b0, 32'h0);
		check(rdData, exp);
	endtask

	task expectTg(input logic [2:0] o, input logic [15:0] d);
		int n;
		n = 0;
		while (tq.size() == 0 && n < 3000)
		begin
			@(posedge sys_clk);
			n++;
		end
		if (tq.size() == 0)
			timeout;
		ent = tq.pop_front();
		check({29'h0, ent[18:16]}, {29'h0, o});
		check({16'h0, ent[15:0]}, {16'h0, d});
		stamp = int'(ent[50:19]);
	endtask

	task expectNone(input int n);
		repeat (n) @(posedge sys_clk);
		check(tq.size(), 32'h0);
	endtask

	task endTest(input string s);
		$display("test %s done", s);
	endtask

	initial
	begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		rdCheck(`PBV_OFS_MODE, 32'h010);
		rdCheck(`PBV_OFS_RISE, 32'h4);
		rdCheck(`PBV_OFS_FALL, 32'h0);
		rdCheck(`PBV_OFS_FACTOR, 32'h3);
		rdCheck(6'h24, 32'h0);
		xfer(`PBV_OFS_RISE, 1'b1, 32'h1f);
		rdCheck(`PBV_OFS_RISE, 32'h1e);
		xfer(`PBV_OFS_FACTOR, 1'b1, 32'h1);
		rdCheck(`PBV_OFS_FACTOR, 32'h3);
		xfer(`PBV_OFS_RISE, 1'b1, 32'h5);
		xfer(`PBV_OFS_FALL, 1'b1, 32'h2);
		rdCheck(`PBV_OFS_STATUS, 32'h280);
		endTest("registers");
		for (int m = 0; m < 3; m++)
		begin
			xfer(`PBV_OFS_MODE, 1'b1, 32'h180 | m);
			i_pbv_contact_model.setContact(1'b1);
			if (m != 1)
				expectTg(`PBV_OBJ_VALUE, 16'd250);
			i_pbv_contact_model.setContact(1'b0);
			if (m != 0)
				expectTg(`PBV_OBJ_VALUE, 16'd100);
			expectNone(10);
		end
		endTest("edge modes");
		xfer(`PBV_OFS_MODE, 1'b1, 32'h184);
		i_pbv_contact_model.setContact(1'b1);
		expectTg(`PBV_OBJ_VALUE, 16'd250);
		expectTg(`PBV_OBJ_VALUE, 16'd200);
		t0 = stamp;
		expectTg(`PBV_OBJ_VALUE, 16'd150);
		check(stamp - t0, 32'd1560);
		i_pbv_contact_model.setContact(1'b0);
		expectNone(20);
		i_pbv_contact_model.setContact(1'b1);
		expectTg(`PBV_OBJ_VALUE, 16'd150);
		i_pbv_contact_model.setContact(1'b0);
		xfer(`PBV_OFS_MODE, 1'b1, 32'h186);
		i_pbv_contact_model.setContact(1'b1);
		expectTg(`PBV_OBJ_VALUE, 16'd250);
		expectNone(1800);
		i_pbv_contact_model.setContact(1'b0);
		expectTg(`PBV_OBJ_VALUE, 16'd100);
		endTest("adjustment");
		// Lane 0 only: the upper delay byte must keep its zero
		avs_byteenable <= 4'h1;
		xfer(`PBV_OFS_PWRDLY, 1'b1, 32'h0305);
		avs_byteenable <= 4'hf;
		rdCheck(`PBV_OFS_PWRDLY, 32'h5);
		for (int p = 0; p < 3; p++)
		begin
			xfer(`PBV_OFS_MODE, 1'b1, p == 0 ? 32'h1a0 : p == 1 ? 32'h1e2 : 32'h1a1);
			i_pbv_contact_model.setBus(1'b0);
			i_pbv_contact_model.setBus(1'b1);
			t0 = cyc;
			if (p == 2)
				expectNone(60);
			else
				expectTg(`PBV_OBJ_VALUE, p == 0 ? 16'd250 : 16'd100);
			if (p != 2)
				check(stamp - t0 >= 20, 32'h1);
		end
		endTest("bus return");
		xfer(`PBV_OFS_MODE, 1'b1, 32'h000);
		xfer(`PBV_OFS_DISCFG, 1'b1, 32'h1);
		xfer(`PBV_OFS_DISACT, 1'b1, 32'h39);
		xfer(`PBV_OFS_DISOBJ, 1'b1, 32'h1);
		expectTg(`PBV_OBJ_SW1, 16'h1);
		expectTg(`PBV_OBJ_SW2, 16'h1);
		xfer(`PBV_OFS_DISOBJ, 1'b1, 32'h0);
		expectTg(`PBV_OBJ_SW1, 16'h0);
		expectNone(10);
		for (int i = 0; i < 3; i++)
		begin
			xfer(`PBV_OFS_MODE, 1'b1, {23'h0, dm[i]});
			xfer(`PBV_OFS_DISACT, 1'b1, {24'h0, da[i]});
			xfer(`PBV_OFS_DISOBJ, 1'b1, 32'h1);
			expectTg(dob[i], ds[i]);
			xfer(`PBV_OFS_DISOBJ, 1'b1, 32'h1);
			i_pbv_contact_model.setContact(1'b1);
			i_pbv_contact_model.setContact(1'b0);
			expectNone(20);
			xfer(`PBV_OFS_DISOBJ, 1'b1, 32'h0);
			expectTg(dob[i], de[i]);
		end
		xfer(`PBV_OFS_DISCFG, 1'b1, 32'h0);
		xfer(`PBV_OFS_DISOBJ, 1'b1, 32'h1);
		expectNone(10);
		xfer(`PBV_OFS_DISCFG, 1'b1, 32'h3);
		xfer(`PBV_OFS_DISOBJ, 1'b1, 32'h0);
		expectTg(`PBV_OBJ_VALUE, 16'd250);
		xfer(`PBV_OFS_DISOBJ, 1'b1, 32'h1);
		expectTg(`PBV_OBJ_VALUE, 16'd100);
		endTest("disable");
		test_done;
	end
endmodule

bind pbv_channel pbv_channel_checker #(.CYC_PER_MS(CYC_PER_MS)) i_pbv_channel_checker (
	.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .contactIn(contactIn),
	.busVoltOk(busVoltOk), .tgValid(tgValid), .tgObject(tgObject), .tgData(tgData));
`default_nettype wire

/* File: pbv_consts.vh */
// Constants for the push-button brightness value and disable channel
`ifndef PBV_CONSTS_VH
`define PBV_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PBV_OFS_MODE    6'h00
`define PBV_OFS_RISE    6'h04
`define PBV_OFS_FALL    6'h08
`define PBV_OFS_FACTOR  6'h0c
`define PBV_OFS_DISCFG  6'h10
`define PBV_OFS_DISACT  6'h14
`define PBV_OFS_DISOBJ  6'h18
`define PBV_OFS_PWRDLY  6'h1c
`define PBV_OFS_STATUS  6'h20

// ----------------------------------------------------------------
// Field encodings and reset values
// ----------------------------------------------------------------
`define PBV_EDGE_RISE   2'h0
`define PBV_EDGE_FALL   2'h1
`define PBV_EDGE_BOTH   2'h2
`define PBV_FUNC_SWITCH 2'h0
`define PBV_FUNC_DIM    2'h1
`define PBV_FUNC_BLIND  2'h2
`define PBV_FUNC_VALUE  2'h3
`define PBV_ACT_NONE    2'h0
`define PBV_ACT_A       2'h1
`define PBV_ACT_B       2'h2
`define PBV_ACT_C       2'h3
`define PBV_OBJ_VALUE   3'h0
`define PBV_OBJ_SW1     3'h1
`define PBV_OBJ_SW2     3'h2
`define PBV_OBJ_DIMSW   3'h3
`define PBV_OBJ_BLIND   3'h4
`define PBV_MODE_RST    9'h010
`define PBV_RISE_RST    5'h04
`define PBV_FALL_RST    5'h00
`define PBV_IDX_MAX     5'h1e
`define PBV_FACTOR_MIN  7'h03
`define PBV_FACTOR_RST  7'h03

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PBV_CLK_PERIOD_PS 4000
`define PBV_MS_PS         1000000000
// Clock cycles per millisecond at the 4 ns system clock, sized for the prescaler
`define PBV_CYC_PER_MS    18'd250000
`define PBV_BASE0_MS      10'h082
`define PBV_BASE1_MS      10'h104
`define PBV_BASE2_MS      10'h208
`define PBV_BASE3_MS      10'h3e8
`define PBV_LONG_MS       17'h00190

`endif

/* File: pbv_contact_model.sv */
// Contact and bus supply model driving the channel's far-side inputs
`timescale 1ns/1ps
`default_nettype none

module pbv_contact_model (
	input wire logic sys_clk,   // clock
	output var logic contactIn, // contact level
	output var logic busVoltOk  // bus power
);
	initial contactIn = 1'b0;
	initial busVoltOk = 1'b1;

	task setContact(input logic v);
		@(posedge sys_clk);
		contactIn <= v;
	endtask

	task setBus(input logic v);
		@(posedge sys_clk);
		busVoltOk <= v;
	endtask
endmodule
`default_nettype wire
